//--- rtl/i2cs_pkg.sv
package i2cs_pkg;
	localparam int          ADDR_W       = 3;
	localparam logic [2:0]  REG_CONTROL  = 3'h0;
	localparam logic [2:0]  REG_STATUS   = 3'h1;
	localparam logic [2:0]  REG_RECEIVE  = 3'h2;
	localparam logic [2:0]  REG_TRANSMIT = 3'h3;
	localparam logic [2:0]  REG_OWN_ADDR = 3'h4;
	localparam logic [2:0]  REG_BAUD     = 3'h5;
	// control bit positions
	localparam int          CTL_ENABLE   = 15;
	localparam int          CTL_RELEASE  = 12;
	localparam int          CTL_TEN_BIT  = 10;
	localparam int          CTL_GEN_CALL = 7;
	localparam int          CTL_STRETCH  = 6;
	// status bit positions, bits below STAT_RO_W are read only
	localparam int          STAT_RX_FULL = 0;
	localparam int          STAT_TX_FULL = 1;
	localparam int          STAT_RW      = 2;
	localparam int          STAT_TEN_HIT = 3;
	localparam int          STAT_RO_W    = 6;
	localparam int          STAT_OVER    = 6;
	localparam logic [15:0] CTL_RESET    = 16'h0000;
	localparam logic [9:0]  STAT_RESET   = 10'h000;
	localparam logic [4:0]  TEN_HEADER   = 5'h1E;
	localparam logic [3:0]  BITS_BYTE    = 4'h8;
	localparam logic [3:0]  BITS_ACK     = 4'h9;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HDR  = 3'b001,
		ST_LOW  = 3'b011,
		ST_RX   = 3'b010,
		ST_TX   = 3'b110
	} i2cs_state_type;
endpackage

//--- rtl/i2cs_pin_sync.sv
`timescale 1ns/1ps
module i2cs_pin_sync (
	input  wire logic core_clk, // system clock
	input  wire logic rst_b,    // synchronous reset, active low
	input  wire logic pin,      // asynchronous pin level
	output logic      level,    // synchronised level
	output logic      rise,     // one-cycle pulse on rising edge
	output logic      fall      // one-cycle pulse on falling edge
);
	logic meta;
	logic prev;

	// bus idles high, so reset to high to avoid a false edge
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			meta  <= 1'b1;
			level <= 1'b1;
			prev  <= 1'b1;
		end else begin
			meta  <= pin;
			level <= meta;
			prev  <= level;
		end
	end

	assign rise = level & ~prev;
	assign fall = ~level & prev;
endmodule

//--- rtl/i2cs_slave.sv
`timescale 1ns/1ps
// Notes on behaviour
// - when enabled, idle until Start, then shift eight bits before comparing
// - every incoming bit sampled on rising edge of clock line
// - ten-bit select clear: own address is 7-bit, low seven bits compared
// - 7-bit: own address 6..0 against shift 7..1, shift bit 0 is direction
// - on match: acknowledge, event at ninth fall, address into receive buffer, full set
// - 10-bit header: shift 7..3 equals 11110, shift 2..1 equals own address 9..8
// - header match with write: event, clear ten-bit match; else clear and idle
// - next byte against own address 7..0: match sets ten-bit match, else idle
// - after Restart in 10-bit mode a read needs only the header byte to match
// - direction one: acknowledge, hold clock low until software loads and releases
// - transmit data changes after clock falls, stable while clock high
// - transmit: event on ninth fall of each byte, acknowledged or not
// - receive: buffer loaded only when not full, acknowledge on ninth clock
// - buffer still full: no acknowledge, no load, event still raised
// - overflow set but buffer empty: buffer loaded, not acknowledged
// - receive double buffered with event per byte; transmit double buffered (holding and shift)
// - status low six bits read only, upper bits read/write; control read/write except bit 12, which reads back the clock release
// - 9-bit baud reload, 10-bit own address, 8-bit transmit and receive
// - 0x78..0x7B headers only used in 10-bit mode; others compare directly
// - general call enable also matches all-zero address with write, in 7-bit mode only
// - stretch enable in receive holds clock low after each full byte
module i2cs_slave (
	input  wire logic                      core_clk,     // 200 MHz system clock
	input  wire logic                      rst_b,        // synchronous reset, active low
	input  wire logic [i2cs_pkg::ADDR_W-1:0] reg_addr,   // register index
	input  wire logic [15:0]               reg_wdata,    // write data
	input  wire logic                      reg_wr,       // write strobe
	input  wire logic                      reg_rd,       // read strobe
	output logic      [15:0]               reg_rdata,    // read data, cycle after strobe
	input  wire logic                      scl_i,        // clock line level
	output logic                           scl_o,        // clock line drive value
	output logic                           scl_oe,       // clock line pulled low
	input  wire logic                      sda_i,        // data line level
	output logic                           sda_o,        // data line drive value
	output logic                           sda_oe,       // data line pulled low
	output logic                           slave_event_flag // one-cycle slave event
);
	import i2cs_pkg::*;

	logic [15:0]    port_control;
	logic [9:0]     own_slave_address;
	logic [8:0]     baud_reload;
	logic [7:0]     transmit_holding;
	logic [7:0]     receive_buffer;
	logic [9:0]     status_upper;
	logic           receive_full_flag;
	logic           transmit_full_flag;
	logic           ten_bit_match_status;
	logic           clock_release;
	logic           dir_read;
	i2cs_state_type state;
	i2cs_state_type next_state;
	logic [3:0]     bit_cnt;
	logic [7:0]     serial_shift_register;
	logic [7:0]     tx_shift;
	logic           addr_byte;
	logic           master_ack;
	logic           scl_lvl, scl_rise, scl_fall;
	logic           sda_lvl, sda_rise, sda_fall;
	logic           module_enable, ten_bit_address_select;
	logic           general_call_enable, stretch_enable;
	logic           receive_overflow_flag;
	logic           start_det, stop_det, active;
	logic           byte_end, ninth_end;
	logic           next_ack, load_rcv, set_ovf, set_ten, clr_ten, to_addr, tx_load;
	logic           hw_hold, hdr10_ok;

	assign module_enable          = port_control[CTL_ENABLE];
	assign ten_bit_address_select = port_control[CTL_TEN_BIT];
	assign general_call_enable    = port_control[CTL_GEN_CALL];
	assign stretch_enable         = port_control[CTL_STRETCH];
	assign receive_overflow_flag  = status_upper[STAT_OVER-STAT_RO_W];

	i2cs_pin_sync u_scl (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pin      (scl_i),
		.level    (scl_lvl),
		.rise     (scl_rise),
		.fall     (scl_fall)
	);

	i2cs_pin_sync u_sda (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pin      (sda_i),
		.level    (sda_lvl),
		.rise     (sda_rise),
		.fall     (sda_fall)
	);

	assign start_det = module_enable & scl_lvl & sda_fall;
	assign stop_det  = scl_lvl & sda_rise;
	assign active    = (state != ST_IDLE);
	assign byte_end  = active & scl_fall & (bit_cnt == BITS_BYTE);
	assign ninth_end = active & scl_fall & (bit_cnt == BITS_ACK);
	assign hdr10_ok  = (serial_shift_register[7:3] == TEN_HEADER)
		&& (serial_shift_register[2:1] == own_slave_address[9:8]);

	// byte decision, evaluated when the eighth clock falls
	always_comb begin
		next_state = state;
		next_ack   = 1'b0;
		load_rcv   = 1'b0;
		set_ovf    = 1'b0;
		set_ten    = 1'b0;
		clr_ten    = 1'b0;
		to_addr    = 1'b0;
		unique case (state)
			ST_IDLE: next_state = ST_IDLE;
			ST_HDR: begin
				to_addr = 1'b1;
				if (!ten_bit_address_select) begin
					if ((serial_shift_register[7:1] == own_slave_address[6:0])
						|| (general_call_enable && serial_shift_register == 8'h00)) begin
						next_ack   = 1'b1;
						load_rcv   = 1'b1;
						next_state = serial_shift_register[0] ? ST_TX : ST_RX;
					end else begin
						next_state = ST_IDLE;
					end
				end else if (hdr10_ok && serial_shift_register[0] && ten_bit_match_status) begin
					next_ack   = 1'b1;
					load_rcv   = 1'b1;
					next_state = ST_TX;
				end else if (hdr10_ok && !serial_shift_register[0]) begin
					next_ack   = 1'b1;
					load_rcv   = 1'b1;
					clr_ten    = 1'b1;
					next_state = ST_LOW;
				end else begin
					clr_ten    = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_LOW: begin
				to_addr = 1'b1;
				if (serial_shift_register == own_slave_address[7:0]) begin
					next_ack   = 1'b1;
					set_ten    = 1'b1;
					next_state = ST_RX;
				end else begin
					clr_ten    = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_RX: begin
				if (receive_full_flag) begin
					set_ovf = 1'b1;
				end else begin
					load_rcv = 1'b1;
					next_ack = !receive_overflow_flag;
				end
			end
			ST_TX: next_state = ST_TX;
		endcase
	end

	// clock held after ninth fall: always on address read, else when master acked and transmit data is missing or, with stretch, receive buffer is full
	assign hw_hold = ninth_end && (
		(state == ST_TX && (addr_byte || (master_ack && !transmit_full_flag))) ||
		(state == ST_RX && stretch_enable && receive_full_flag));
	assign tx_load = (state == ST_TX) && (bit_cnt == 4'h0) && !scl_lvl && transmit_full_flag;

	// protocol engine
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state                 <= ST_IDLE;
			bit_cnt               <= 4'h0;
			serial_shift_register <= 8'h00;
			tx_shift              <= 8'h00;
			sda_oe                <= 1'b0;
			addr_byte             <= 1'b0;
			master_ack            <= 1'b0;
			slave_event_flag      <= 1'b0;
		end else begin
			slave_event_flag <= 1'b0;
			if (!module_enable || stop_det) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (start_det) begin
				state   <= ST_HDR;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end else begin
				if (scl_rise && active && bit_cnt != BITS_ACK) begin
					serial_shift_register <= {serial_shift_register[6:0], sda_lvl};
					bit_cnt               <= bit_cnt + 4'h1;
					if (bit_cnt == BITS_BYTE) begin
						master_ack <= !sda_lvl;
					end
				end
				if (byte_end) begin
					state     <= next_state;
					addr_byte <= to_addr;
					sda_oe    <= (state == ST_TX) ? 1'b0 : next_ack;
				end else if (ninth_end) begin
					slave_event_flag <= 1'b1;
					bit_cnt          <= 4'h0;
					sda_oe           <= 1'b0;
					if (state == ST_TX && !addr_byte && !master_ack) begin
						state <= ST_IDLE;
					end
				end else if (tx_load) begin
					tx_shift <= transmit_holding;
					sda_oe   <= !transmit_holding[7];
				end else if (state == ST_TX && scl_fall && bit_cnt != 4'h0) begin
					tx_shift <= {tx_shift[6:0], 1'b0};
					sda_oe   <= !tx_shift[6];
				end
			end
		end
	end

	assign scl_o  = 1'b0;
	assign sda_o  = 1'b0;
	assign scl_oe = module_enable && active && !clock_release;

	// software registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			port_control      <= CTL_RESET;
			own_slave_address <= 10'h000;
			baud_reload       <= 9'h000;
			transmit_holding  <= 8'h00;
		end else if (reg_wr) begin
			unique case (reg_addr)
				REG_CONTROL:  port_control      <= reg_wdata;
				REG_OWN_ADDR: own_slave_address <= reg_wdata[9:0];
				REG_BAUD:     baud_reload       <= reg_wdata[8:0];
				REG_TRANSMIT: transmit_holding  <= reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	// flags that both software and the engine touch; hardware sets win, except that a software release beats a hardware clock hold
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			receive_buffer       <= 8'h00;
			receive_full_flag    <= 1'b0;
			transmit_full_flag   <= 1'b0;
			ten_bit_match_status <= 1'b0;
			status_upper         <= STAT_RESET;
			clock_release        <= 1'b1;
			dir_read             <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == REG_STATUS) begin
				status_upper <= reg_wdata[15:STAT_RO_W];
			end
			if (set_ovf && byte_end) begin
				status_upper[STAT_OVER-STAT_RO_W] <= 1'b1;
			end
			if (reg_rd && reg_addr == REG_RECEIVE) begin
				receive_full_flag <= 1'b0;
			end
			if (load_rcv && byte_end) begin
				receive_buffer    <= serial_shift_register;
				receive_full_flag <= 1'b1;
				if (to_addr) begin
					dir_read <= serial_shift_register[0];
				end
			end
			// a byte written as the old one is taken must still count as pending
			if (reg_wr && reg_addr == REG_TRANSMIT) begin
				transmit_full_flag <= 1'b1;
			end else if (tx_load) begin
				transmit_full_flag <= 1'b0;
			end
			if (byte_end && set_ten) begin
				ten_bit_match_status <= 1'b1;
			end else if (byte_end && clr_ten) begin
				ten_bit_match_status <= 1'b0;
			end
			// software may only clear the release bit when stretching is enabled
			if (reg_wr && reg_addr == REG_CONTROL && reg_wdata[CTL_RELEASE]) begin
				clock_release <= 1'b1;
			end else if (hw_hold) begin
				clock_release <= 1'b0;
			end else if (reg_wr && reg_addr == REG_CONTROL && stretch_enable) begin
				clock_release <= 1'b0;
			end
		end
	end

	// read port
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CONTROL: begin
					reg_rdata              <= port_control;
					reg_rdata[CTL_RELEASE] <= clock_release;
				end
				REG_STATUS: reg_rdata <= {status_upper, 2'b00, ten_bit_match_status,
					dir_read, transmit_full_flag, receive_full_flag};
				REG_RECEIVE:  reg_rdata <= {8'h00, receive_buffer};
				REG_TRANSMIT: reg_rdata <= {8'h00, transmit_holding};
				REG_OWN_ADDR: reg_rdata <= {6'h00, own_slave_address};
				REG_BAUD:     reg_rdata <= {7'h00, baud_reload};
				default:      reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence seq_byte_end;
		byte_end;
	endsequence

	sequence seq_ninth_end;
		ninth_end && !start_det && !stop_det && module_enable;
	endsequence

	a_idle_no_drive: assert property (state == ST_IDLE && $past(state) == ST_IDLE
		|-> !sda_oe && !scl_oe) else $error("idle slave drives a line");

	a_bit_sampled: assert property (scl_rise && active && bit_cnt < BITS_BYTE
		&& module_enable && !stop_det && !start_det
		|=> serial_shift_register[0] == $past(sda_lvl)) else $error("bit not sampled");

	a_seven_match: assert property (seq_byte_end ##0 (state == ST_HDR
		&& !ten_bit_address_select && module_enable && !stop_det && !start_det
		&& serial_shift_register[7:1] == own_slave_address[6:0])
		|=> sda_oe && receive_full_flag
		&& receive_buffer == $past(serial_shift_register)) else $error("7-bit match lost");

	a_ten_header: assert property (seq_byte_end ##0 (state == ST_HDR
		&& ten_bit_address_select && hdr10_ok && !serial_shift_register[0]
		&& module_enable && !stop_det && !start_det)
		|=> state == ST_LOW && !ten_bit_match_status && sda_oe) else $error("header");

	a_ten_low: assert property (seq_byte_end ##0 (state == ST_LOW && module_enable
		&& !stop_det && !start_det && serial_shift_register == own_slave_address[7:0])
		|=> ten_bit_match_status && state == ST_RX) else $error("low byte match");

	a_full_nack: assert property (seq_byte_end ##0 (state == ST_RX && receive_full_flag
		&& module_enable && !stop_det && !start_det)
		|=> !sda_oe && receive_overflow_flag
		&& receive_buffer == $past(receive_buffer)) else $error("overrun accepted");

	a_event_ninth: assert property (seq_ninth_end |=> slave_event_flag ##1 !slave_event_flag)
		else $error("ninth-clock event missing");

	a_tx_hold: assert property (seq_ninth_end ##0 (state == ST_TX && addr_byte
		&& !(reg_wr && reg_addr == REG_CONTROL && reg_wdata[CTL_RELEASE]))
		|=> scl_oe) else $error("clock not held after read address");

	a_tx_stable_high: assert property (state == ST_TX && $past(state) == ST_TX
		&& scl_lvl && $past(scl_lvl) && !scl_fall && $past(bit_cnt) != 4'h0
		|-> $stable(sda_oe)) else $error("data moved while clock high");
endmodule

//--- verif/i2cs_master_model.sv
`timescale 1ns/1ps
module i2cs_master_model (
	input  wire logic scl_line, // resolved clock line
	input  wire logic sda_line, // resolved data line
	output logic      scl_low,  // pull clock line low
	output logic      sda_low   // pull data line low
);
	localparam real Q = 31.25;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// slave may stretch, so the wait for a high clock is bounded
	task automatic rise_scl();
		scl_low = 1'b0;
		for (int n = 0; n < 4000 && scl_line !== 1'b1; n++)
			#5;
	endtask
	task automatic bit_out(input logic b);
		sda_low = ~b;
		#Q rise_scl();
		#(2*Q) scl_low = 1'b1;
		#Q;
	endtask
	task automatic bit_in(output logic b);
		sda_low = 1'b0;
		#Q rise_scl();
		#Q b = sda_line;
		#Q scl_low = 1'b1;
		#Q;
	endtask
	task automatic start();
		sda_low = 1'b1;
		#(2*Q) scl_low = 1'b1;
		#Q;
	endtask
	task automatic restart();
		sda_low = 1'b0;
		#Q rise_scl();
		#Q sda_low = 1'b1;
		#Q scl_low = 1'b1;
		#Q;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#Q rise_scl();
		#Q sda_low = 1'b0;
		#(2*Q);
	endtask
	// most significant bit first, ninth clock carries the answer
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic nack;
		for (int i = 7; i >= 0; i--)
			bit_out(d[i]);
		bit_in(nack);
		ack = ~nack;
	endtask
	task automatic byte_in(output logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--)
			bit_in(d[i]);
		bit_out(~ack);
	endtask
endmodule

//--- verif/i2cs_slave_tb.sv
`timescale 1ns/1ps
module i2cs_slave_tb;
	import i2cs_pkg::*;
	logic        core_clk;
	logic        rst_b     = 1'b0;
	logic [2:0]  reg_addr  = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [15:0] reg_rdata;
	logic        scl_oe;
	logic        sda_oe;
	logic        slave_event_flag;
	logic        scl_o;
	logic        sda_o;
	logic        scl_low;
	logic        sda_low;
	wire         scl_line  = ~(scl_oe | scl_low);
	wire         sda_line  = ~(sda_oe | sda_low);
	int          mismatches   = 0;
	int          total_checks = 0;
	int          events       = 0;
	int          ev_exp       = 0;
	int          cycles       = 0;

	i2cs_slave i_i2cs_slave (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe(sda_oe), .slave_event_flag(slave_event_flag));
	i2cs_master_model i_i2cs_master_model (.scl_line(scl_line), .sda_line(sda_line),
		.scl_low(scl_low), .sda_low(sda_low));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (slave_event_flag === 1'b1)
			events <= events + 1;
		if (cycles == 30000) begin
			mismatches++;
			wrap_up();
		end
	end
	always @(sda_oe)
		if (rst_b === 1'b1)
			check({15'h0, scl_line}, 16'h0, "data moved, clock high");

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, exp, input string what);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [15:0] m, e, input string w);
		logic [15:0] d;
		rd(a, d);
		check(d & m, e, w);
	endtask
	task automatic send(input logic [7:0] b, input logic e);
		logic a;
		i_i2cs_master_model.byte_out(b, a);
		check({15'h0, a}, {15'h0, e}, "ack");
	endtask
	// event pulses lag the ninth fall by a few cycles
	task automatic ev_chk(input int n);
		repeat (10) @(posedge core_clk);
		ev_exp += n;
		check(16'(events), 16'(ev_exp), "event count");
	endtask

	task automatic t_regs();
		rd_chk(REG_CONTROL, 16'hFFFF, 16'h1000, "ctl reset");
		check({14'h0, scl_o, sda_o}, 16'h0, "drive values");
		wr(REG_CONTROL, 16'h5A3C);
		rd_chk(REG_CONTROL, 16'hFFFF, 16'h5A3C, "ctl rw");
		wr(REG_STATUS, 16'hFFFF);
		rd_chk(REG_STATUS, 16'hFFFF, 16'hFFC0, "stat ro");
		wr(REG_STATUS, 16'h0000);
		wr(REG_OWN_ADDR, 16'hFFFF);
		rd_chk(REG_OWN_ADDR, 16'hFFFF, 16'h03FF, "own width");
		wr(REG_BAUD, 16'hFFFF);
		rd_chk(REG_BAUD, 16'hFFFF, 16'h01FF, "baud width");
		wr(REG_RECEIVE, 16'hFFFF);
		rd_chk(REG_RECEIVE, 16'hFFFF, 16'h0000, "rcv ro");
		rd_chk(3'h6, 16'hFFFF, 16'h0000, "unmapped");
		$display("test regs done");
	endtask
	task automatic t_write();
		wr(REG_CONTROL, 16'h9000);
		wr(REG_OWN_ADDR, 16'h033C);
		i_i2cs_master_model.start();
		send(8'h78, 1'b1);
		rd_chk(REG_STATUS, 16'hFFFF, 16'h0001, "addr full");
		send(8'hC3, 1'b0);
		rd_chk(REG_STATUS, 16'hFFFF, 16'h0041, "overflow");
		rd_chk(REG_RECEIVE, 16'hFFFF, 16'h0078, "kept");
		send(8'h96, 1'b0);
		rd_chk(REG_RECEIVE, 16'hFFFF, 16'h0096, "ovf load");
		wr(REG_STATUS, 16'h0000);
		send(8'h5E, 1'b1);
		rd_chk(REG_RECEIVE, 16'hFFFF, 16'h005E, "data");
		i_i2cs_master_model.stop();
		ev_chk(4);
		$display("test write done");
	endtask
	task automatic t_miss();
		logic [7:0] miss [3] = '{8'h7A, 8'h00, 8'hF0};
		for (int i = 0; i < 3; i++) begin
			i_i2cs_master_model.start();
			send(miss[i], 1'b0);
			i_i2cs_master_model.stop();
		end
		ev_chk(0);
		wr(REG_CONTROL, 16'h9080);
		i_i2cs_master_model.start();
		send(8'h00, 1'b1);
		i_i2cs_master_model.stop();
		rd_chk(REG_RECEIVE, 16'hFFFF, 16'h0000, "gcall");
		ev_chk(1);
		$display("test miss done");
	endtask
	task automatic t_read();
		logic [15:0] d;
		logic [7:0]  b;
		wr(REG_CONTROL, 16'h9000);
		i_i2cs_master_model.start();
		send(8'h79, 1'b1);
		ev_chk(1);
		check({15'h0, scl_oe}, 16'h1, "held");
		rd_chk(REG_STATUS, 16'h0004, 16'h0004, "dir");
		rd(REG_RECEIVE, d);
		wr(REG_TRANSMIT, 16'hFFA5);
		rd_chk(REG_TRANSMIT, 16'hFFFF, 16'h00A5, "tx width");
		wr(REG_CONTROL, 16'h9000);
		repeat (2) @(posedge core_clk);
		check({15'h0, scl_oe}, 16'h0, "freed");
		i_i2cs_master_model.byte_in(b, 1'b1);
		check({8'h0, b}, 16'h00A5, "tx byte");
		ev_chk(1);
		wr(REG_TRANSMIT, 16'h003C);
		wr(REG_CONTROL, 16'h9000);
		i_i2cs_master_model.byte_in(b, 1'b0);
		check({8'h0, b}, 16'h003C, "tx byte");
		i_i2cs_master_model.stop();
		ev_chk(1);
		$display("test read done");
	endtask
	task automatic t_ten();
		logic [15:0] d;
		logic [7:0]  b;
		wr(REG_CONTROL, 16'h9400);
		wr(REG_OWN_ADDR, 16'h02A7);
		i_i2cs_master_model.start();
		send(8'hF4, 1'b1);
		rd_chk(REG_STATUS, 16'h0008, 16'h0000, "partial");
		rd(REG_RECEIVE, d);
		send(8'hA7, 1'b1);
		rd_chk(REG_STATUS, 16'h0008, 16'h0008, "matched");
		i_i2cs_master_model.restart();
		send(8'hF5, 1'b1);
		rd(REG_RECEIVE, d);
		wr(REG_TRANSMIT, 16'h0011);
		wr(REG_CONTROL, 16'h9400);
		i_i2cs_master_model.byte_in(b, 1'b0);
		check({8'h0, b}, 16'h0011, "ten read");
		i_i2cs_master_model.stop();
		ev_chk(4);
		i_i2cs_master_model.start();
		send(8'hF6, 1'b0);
		i_i2cs_master_model.stop();
		rd_chk(REG_STATUS, 16'h0008, 16'h0000, "cleared");
		ev_chk(0);
		$display("test ten done");
	endtask
	task automatic t_stretch();
		wr(REG_CONTROL, 16'h9040);
		wr(REG_OWN_ADDR, 16'h003C);
		i_i2cs_master_model.start();
		send(8'h78, 1'b1);
		ev_chk(1);
		check({15'h0, scl_oe}, 16'h1, "rx held");
		rd_chk(REG_RECEIVE, 16'hFFFF, 16'h0078, "rx addr");
		wr(REG_CONTROL, 16'h9040);
		repeat (2) @(posedge core_clk);
		check({15'h0, scl_oe}, 16'h0, "rx freed");
		send(8'h5A, 1'b1);
		ev_chk(1);
		check({15'h0, scl_oe}, 16'h1, "rx held");
		rd_chk(REG_RECEIVE, 16'hFFFF, 16'h005A, "rx data");
		wr(REG_CONTROL, 16'h9040);
		i_i2cs_master_model.stop();
		$display("test stretch done");
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		t_regs();
		t_write();
		t_miss();
		t_read();
		t_ten();
		t_stretch();
		wrap_up();
	end
endmodule
